// ==== bench/ppf_board_assertions.sv ====
// Purpose: Port-level checks for the board status and control block.
// Assumes: Bound to ppf_board; one clock domain, reset active low.
// Notes:   Delays follow the hand-over timing of the block.
`timescale 1ns/1ps
module ppf_board_checker (
   input wire logic        clk_in,
   input wire logic        rst_n_in,
   input wire logic [7:0]  io_addr_in,
   input wire logic        io_wr_in,
   input wire logic        io_rd_in,
   input wire logic [7:0]  io_wdata_in,
   input wire logic [7:0]  io_rdata_out,
   input wire logic [7:0]  pout_data_out,
   input wire logic        pout_data_oe_n_out,
   input wire logic        pout_ack_in,
   input wire logic        pout_aux_out,
   input wire logic        pout_write_out,
   input wire logic        latch_oe_strap_in,
   input wire logic        ack_rise_strap_in,
   input wire logic        aux_strobe_en_in,
   input wire logic [1:0]  ser_rx_rdy_in,
   input wire logic        arm_in_flag_in,
   input wire logic        arm_out_flag_in,
   input wire logic        tick_irq_route_in,
   input wire logic [15:0] irq_route_in,
   input wire logic [9:0]  irq_line_out,
   input wire logic [3:0]  irq_group_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   // The write indication and the byte itself follow a data-port write.
   property p_wr_ind;
      io_wr_in && io_addr_in == 8'h00 |=> pout_write_out;
   endproperty
   a_wr_ind: assert property (p_wr_ind)
      else $error("no write indication");
   property p_latch;
      pout_write_out |=> pout_data_out == $past(io_wdata_in, 2);
   endproperty
   a_latch: assert property (p_latch)
      else $error("wrong printer byte");
   property p_aux;
      pout_write_out && aux_strobe_en_in |=> pout_aux_out;
   endproperty
   a_aux: assert property (p_aux)
      else $error("missing aux strobe");
   property p_noaux;
      !$past(aux_strobe_en_in) && !aux_strobe_en_in |-> !pout_aux_out;
   endproperty
   a_noaux: assert property (p_noaux)
      else $error("aux strobe while disabled");
   // A strapped-low enable keeps the latch driving from the first clock after reset.
   property p_oe;
      $past(rst_n_in) && !$past(latch_oe_strap_in) |-> !pout_data_oe_n_out;
   endproperty
   a_oe: assert property (p_oe)
      else $error("latch not driving");
   property p_rd;
      io_rd_in && io_addr_in == 8'h06 |=> io_rdata_out[7:3] == 5'h00;
   endproperty
   a_rd: assert property (p_rd)
      else $error("status upper bits set");
   property p_quiet;
      !$past(io_rd_in) |-> io_rdata_out == 8'h00;
   endproperty
   a_quiet: assert property (p_quiet)
      else $error("read data outside a read");
   property p_ack;
      ack_rise_strap_in && arm_out_flag_in && $rose(pout_ack_in)
         |-> ##[1:3] irq_group_out[2];
   endproperty
   a_ack: assert property (p_ack)
      else $error("acknowledge edge did not raise flag");
   property p_dis;
      !arm_in_flag_in && !arm_out_flag_in |=> !irq_group_out[2];
   endproperty
   a_dis: assert property (p_dis)
      else $error("disarmed parallel group requests");
   property p_rx;
      ser_rx_rdy_in[0] |=> irq_group_out[0];
   endproperty
   a_rx: assert property (p_rx)
      else $error("receiver ready not requesting");
   property p_tick;
      !tick_irq_route_in |=> !irq_group_out[3];
   endproperty
   a_tick: assert property (p_tick)
      else $error("unrouted tick requests");
   property p_route;
      irq_group_out[1] && irq_route_in[7:4] == 4'h9 && $stable(irq_route_in)
         |-> irq_line_out[9];
   endproperty
   a_route: assert property (p_route)
      else $error("group not on its line");
   c_aux: cover property (pout_aux_out);
   c_line: cover property (irq_line_out[9]);
   c_key: cover property (io_rd_in && io_addr_in == 8'h00);
endmodule : ppf_board_checker

// ==== bench/ppf_periph.sv ====
// Purpose: Printer and keyboard as seen from the parallel connectors.
// Assumes: Behavioural; lines change just after a clock edge.
// Notes:   Idle levels follow the straps, so a strap change makes an edge.
`timescale 1ns/1ps
module ppf_periph (
   input  wire logic       clk_in,
   input  wire logic [7:0] data_in,
   input  wire logic       aux_in,
   input  wire logic       ack_rise_in,
   input  wire logic       stb_rise_in,
   input  wire logic [3:0] ack_dly_in,
   output logic            ack_out,
   output logic      [7:0] key_data_out,
   output logic            key_stb_out
);
   logic [7:0] got_q[$];
   logic [4:0] cnt   = 5'h00;
   logic       ack_p = 1'h0;
   logic       stb_p = 1'h0;
   initial key_data_out = 8'h00;
   // Pulses are drawn against the idle level the strap expects.
   assign ack_out     = ack_p ^ ~ack_rise_in;
   assign key_stb_out = stb_p ^ ~stb_rise_in;
   // Each strobed byte is kept; one late answer follows a burst.
   always @(posedge clk_in) begin
      if (aux_in) begin
         got_q.push_back(data_in);
         cnt <= {1'h0, ack_dly_in} + 5'h02;
      end else if (cnt != 5'h00) begin
         cnt <= cnt - 5'h01;
      end
      ack_p <= (cnt == 5'h01);
   end
   // After the strobe the data lines show the inverse, not the old byte.
   task send_key(input logic [7:0] b);
      @(posedge clk_in) key_data_out <= b;
      @(posedge clk_in) stb_p <= 1'h1;
      @(posedge clk_in) stb_p <= 1'h0;
      @(posedge clk_in) key_data_out <= ~b;
   endtask : send_key
endmodule : ppf_periph

// ==== bench/tb_top.sv ====
// Purpose: Self-checking bench for the board status and control block.
// Assumes: Short tick base so the timer is seen within a short run.
// Notes:   io_op strobes last one cycle with an idle cycle between them; the printer burst writes back to back.
`timescale 1ns/1ps
module tb_top;
   logic        clk_in = 1'h0, rst_n_in = 1'h0, io_wr_in = 1'h0;
   logic        io_rd_in = 1'h0, pout_data_oe_n_out, pout_ack_in;
   logic [7:0]  io_addr_in = 8'h00, io_wdata_in = 8'h00, q;
   logic [7:0]  io_rdata_out, pout_data_out, pin_data_in;
   logic        pout_aux_out, pout_write_out, pin_strobe_in;
   logic        latch_oe_strap_in = 1'h0, ack_rise_strap_in = 1'h1;
   logic        strobe_rise_strap_in = 1'h1, aux_strobe_en_in = 1'h1;
   logic        arm_in_flag_in = 1'h0, arm_out_flag_in = 1'h0;
   logic        arm_tick_in = 1'h0, tick_irq_route_in = 1'h0;
   logic [3:0]  tick_sel_in = 4'hb, ack_dly = 4'h0, irq_group_out;
   logic [1:0]  ser_rx_rdy_in = 2'h0, ser_sync_in = 2'h0;
   logic [1:0]  ser_tx_rdy_in = 2'h0, ser_tx_empty_in = 2'h0;
   logic [1:0]  arm_tx_rdy_in = 2'h0, arm_tx_empty_in = 2'h0;
   logic [15:0] irq_route_in = 16'h5a9a;
   logic [9:0]  irq_line_out;
   int          n_errors = 0, n_tests = 0, cyc = 0;
   ppf_board #(.TICK_BASE(8)) u_ppf_board (.*);
   ppf_periph u_ppf_periph (.clk_in(clk_in), .data_in(pout_data_out),
      .aux_in(pout_aux_out), .ack_rise_in(ack_rise_strap_in),
      .stb_rise_in(strobe_rise_strap_in), .ack_dly_in(ack_dly),
      .ack_out(pout_ack_in), .key_data_out(pin_data_in),
      .key_stb_out(pin_strobe_in));
   // Clock and a cycle ceiling that cuts a hang short.
   always #2.5 clk_in = ~clk_in;
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         stop_test();
      end
   end
   task check(input string name, input logic [7:0] exp, got);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask : check
   // Read data is taken one cycle after the read strobe.
   task io_op(input logic wr, input logic [7:0] a, d);
      @(posedge clk_in);
      io_addr_in <= a;
      io_wdata_in <= d;
      if (wr) io_wr_in <= 1'h1;
      else io_rd_in <= 1'h1;
      @(posedge clk_in);
      io_wr_in <= 1'h0;
      io_rd_in <= 1'h0;
      #1 q = io_rdata_out;
   endtask : io_op
   task poll(input int b, input logic e);
      for (int i = 0; i < 30 && q[b] !== e; i++) io_op(1'h0, 8'h06, 8'h00);
      check("status flag", 8'(e), 8'(q[b]));
   endtask : poll
   task clear_flag(input logic [7:0] cmd, input int b);
      io_op(1'h1, 8'h06, cmd);
      io_op(1'h0, 8'h06, 8'h00);
      check("cleared flag", 8'h00, 8'(q[b]));
   endtask : clear_flag
   task t_print;
      for (int i = 0; i < 2; i++) begin
         ack_rise_strap_in <= (i == 0);
         ack_dly <= 4'(7 * i);
         arm_out_flag_in <= 1'h1;
         repeat (4) @(posedge clk_in);
         clear_flag(8'h20, 0);
         io_op(1'h1, 8'h00, 8'(8'h5a + i));
         q = 8'h00;
         poll(0, 1'h1);
         check("printer byte", 8'(8'h5a + i), u_ppf_periph.got_q.pop_front());
         check("latch enable", 8'h00, 8'(pout_data_oe_n_out));
      end
      @(posedge clk_in);
      io_addr_in <= 8'h00;
      io_wr_in <= 1'h1;
      for (int i = 1; i < 4; i++) begin
         io_wdata_in <= 8'(i * 8'h11);
         @(posedge clk_in);
      end
      io_wr_in <= 1'h0;
      arm_out_flag_in <= 1'h0;
      repeat (8) @(posedge clk_in);
      for (int i = 1; i < 4; i++)
         check("burst byte", 8'(i * 8'h11), u_ppf_periph.got_q.pop_front());
   endtask : t_print
   task t_key;
      for (int i = 0; i < 2; i++) begin
         strobe_rise_strap_in <= (i == 0);
         repeat (4) @(posedge clk_in);
         clear_flag(8'h30, 1);
         u_ppf_periph.send_key(8'(8'hc3 ^ i));
         poll(1, 1'h1);
         io_op(1'h0, 8'h00, 8'h00);
         check("key byte", 8'(8'hc3 ^ i), q);
      end
   endtask : t_key
   task t_tick;
      tick_irq_route_in <= 1'h1;
      arm_tick_in <= 1'h1;
      tick_sel_in <= 4'h0;
      repeat (20) @(posedge clk_in);
      io_op(1'h0, 8'h06, 8'h00);
      check("tick flag", 8'h04, q & 8'h04);
      check("tick line", 8'h01, 8'(irq_line_out[5]));
      tick_sel_in <= 4'hb;
      clear_flag(8'h50, 2);
      check("tick group", 8'h00, 8'(irq_group_out[3]));
   endtask : t_tick
   task t_irq;
      // No disk transfer is modelled, so requests never overlap one.
      ser_rx_rdy_in <= 2'h2;
      ser_tx_rdy_in <= 2'h1;
      repeat (3) @(posedge clk_in);
      check("groups", 8'h02, 8'(irq_group_out));
      check("line 9", 8'h01, 8'(irq_line_out[9]));
      arm_tx_rdy_in <= 2'h1;
      repeat (3) @(posedge clk_in);
      check("armed group", 8'h03, 8'(irq_group_out));
      ser_rx_rdy_in <= 2'h0;
      ser_tx_rdy_in <= 2'h0;
      repeat (3) @(posedge clk_in);
      check("idle groups", 8'h00, 8'(irq_group_out));
   endtask : t_irq
   task stop_test;
      $display("Checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : stop_test
   // Reset, then each scenario in turn.
   initial begin
      repeat (16) @(posedge clk_in);
      rst_n_in <= 1'h1;
      t_print();
      t_key();
      t_tick();
      t_irq();
      stop_test();
   end
endmodule : tb_top
bind ppf_board ppf_board_checker u_ppf_board_checker (.*);

// ==== src/ppf_board.sv ====
// Purpose: Parallel handshake flags, data ports, tick timer, irq grouping.
// Assumes: Processor I/O cycles are single-cycle strobes synchronous to clk.
// Notes:   Straps are sampled every cycle; change them only while idle.
//
// Overview of operation
// - Output latch drives its byte continuously from the first clock after reset when output enable strap low.
// - Printer acknowledge edge, polarity by strap, sets output-ready flag.
// - Optionally pulse auxiliary line once per byte written to data port.
// - Status port bit 0 shows output-ready flag for software polling.
// - Write to data port 0 loads byte into output latch for printer.
// - Command 20h, 30h, 50h at port 6 clear output, input, tick flags.
// - Keyboard strobe edge, polarity by strap, sets input-ready flag.
// - Input-ready flag is status bit 1; received byte read at port 0.
// - Tick flag set periodically at 3.3280 ms times a power of two.
// - Tick flag reads as status bit 2.
// - Tick flag can optionally be routed as an interrupt source.
// - Eleven conditions combine into four groups: two serial, parallel, tick.
// - Transmit and flag sources are armable; receive and sync always on.
// - Each group is routable to any one of ten bus request lines.
// - Output-write indication high in the cycle before the byte reaches the parallel port.
`timescale 1ns/1ps
module ppf_board #(
   parameter int TICK_BASE = ppf_pkg::TICK_BASE_CYC,
   parameter int DATA_W    = 8
) (
   input  wire logic              clk_in,
   input  wire logic              rst_n_in,
   // Processor I/O port access.
   input  wire logic [7:0]        io_addr_in,
   input  wire logic              io_wr_in,
   input  wire logic              io_rd_in,
   input  wire logic [7:0]        io_wdata_in,
   output logic      [7:0]        io_rdata_out,
   // Printer side.
   output logic      [DATA_W-1:0] pout_data_out,
   output logic                   pout_data_oe_n_out,
   input  wire logic              pout_ack_in,
   output logic                   pout_aux_out,
   output logic                   pout_write_out,
   // Keyboard side.
   input  wire logic [DATA_W-1:0] pin_data_in,
   input  wire logic              pin_strobe_in,
   // Straps.
   input  wire logic              latch_oe_strap_in,
   input  wire logic              ack_rise_strap_in,
   input  wire logic              strobe_rise_strap_in,
   input  wire logic              aux_strobe_en_in,
   input  wire logic [3:0]        tick_sel_in,
   // Serial interrupt conditions: [0] standard port, [1] second port.
   input  wire logic [1:0]        ser_rx_rdy_in,
   input  wire logic [1:0]        ser_sync_in,
   input  wire logic [1:0]        ser_tx_rdy_in,
   input  wire logic [1:0]        ser_tx_empty_in,
   // Arm controls.
   input  wire logic [1:0]        arm_tx_rdy_in,
   input  wire logic [1:0]        arm_tx_empty_in,
   input  wire logic              arm_in_flag_in,
   input  wire logic              arm_out_flag_in,
   input  wire logic              arm_tick_in,
   input  wire logic              tick_irq_route_in,
   // Group routing: 4 bits per group selects line 0..9; others unrouted.
   input  wire logic [15:0]       irq_route_in,
   output logic      [9:0]        irq_line_out,
   output logic      [3:0]        irq_group_out
);
   localparam int NG = ppf_pkg::IRQ_GROUPS;
   localparam int NL = ppf_pkg::IRQ_LINES;

   // Decoded processor accesses.
   logic wr_data, wr_cmd, rd_data, rd_stat;
   assign wr_data = io_wr_in && io_addr_in == ppf_pkg::PORT_DATA;
   assign wr_cmd  = io_wr_in && io_addr_in == ppf_pkg::PORT_STATUS;
   assign rd_data = io_rd_in && io_addr_in == ppf_pkg::PORT_DATA;
   assign rd_stat = io_rd_in && io_addr_in == ppf_pkg::PORT_STATUS;

   // Output data FIFO; a full FIFO drops the write, and fifo_wr_rdy is left unconnected.
   logic              fifo_wr_rdy, fifo_rd_vld, fifo_pop;
   logic [DATA_W-1:0] fifo_q;
   ppf_fifo #(.WIDTH(DATA_W), .DEPTH(ppf_pkg::FIFO_DEPTH)) u_fifo (
      .clk_in       (clk_in),
      .rst_n_in     (rst_n_in),
      .wr_valid_in  (wr_data),
      .wr_ready_out (fifo_wr_rdy),
      .wr_data_in   (io_wdata_in[DATA_W-1:0]),
      .rd_valid_out (fifo_rd_vld),
      .rd_ready_in  (fifo_pop),
      .rd_data_out  (fifo_q)
   );

   // Edge history for acknowledge and strobe.
   logic ack_d_r, ack_d_nxt, stb_d_r, stb_d_nxt;
   logic ack_edge, stb_edge;
   always_comb begin
      ack_d_nxt = pout_ack_in;
      stb_d_nxt = pin_strobe_in;
      ack_edge  = ack_rise_strap_in ? (pout_ack_in && !ack_d_r)
                                    : (!pout_ack_in && ack_d_r);
      stb_edge  = strobe_rise_strap_in ? (pin_strobe_in && !stb_d_r)
                                       : (!pin_strobe_in && stb_d_r);
   end

   // Tick divider: base counter then power-of-two prescaler.
   logic [31:0] base_r, base_nxt;
   logic [10:0] pre_r, pre_nxt;
   logic        tick_evt;
   always_comb begin
      logic        base_wrap;
      logic [10:0] mask;
      base_wrap = base_r == 32'(TICK_BASE - 1);
      base_nxt  = base_wrap ? 32'h0 : base_r + 32'h1;
      mask      = 11'((12'h1 << tick_sel_in) - 12'h1);
      pre_nxt   = base_wrap ? ((pre_r & mask) == mask ? 11'h0
                                                      : pre_r + 11'h1)
                            : pre_r;
      tick_evt  = base_wrap && (pre_r & mask) == mask;
   end

   // Flag, latch and strobe next-state logic.
   logic              out_rdy_r, out_rdy_nxt;
   logic              in_rdy_r, in_rdy_nxt;
   logic              tick_r, tick_nxt;
   logic [DATA_W-1:0] in_lat_r, in_lat_nxt;
   logic [DATA_W-1:0] dout_r, dout_nxt;
   logic              aux_r, aux_nxt, wr_ind_r, wr_ind_nxt;
   logic [7:0]        rdata_r, rdata_nxt;
   always_comb begin
      // A clear never beats a set arriving in the same cycle.
      out_rdy_nxt = ack_edge ||
                    (out_rdy_r && !(wr_cmd &&
                     io_wdata_in == ppf_pkg::CMD_CLR_OUT));
      in_rdy_nxt  = stb_edge ||
                    (in_rdy_r && !(wr_cmd &&
                     io_wdata_in == ppf_pkg::CMD_CLR_IN));
      tick_nxt    = tick_evt ||
                    (tick_r && !(wr_cmd &&
                     io_wdata_in == ppf_pkg::CMD_CLR_TICK));
      in_lat_nxt  = stb_edge ? pin_data_in : in_lat_r;
      fifo_pop    = fifo_rd_vld;
      dout_nxt    = fifo_rd_vld ? fifo_q : dout_r;
      aux_nxt     = aux_strobe_en_in && fifo_rd_vld;
      wr_ind_nxt  = wr_data;
      rdata_nxt   = 8'h00;
      if (rd_stat) begin
         rdata_nxt[ppf_pkg::BIT_OUT_RDY] = out_rdy_r;
         rdata_nxt[ppf_pkg::BIT_IN_RDY]  = in_rdy_r;
         rdata_nxt[ppf_pkg::BIT_TICK]    = tick_r;
      end else if (rd_data) begin
         rdata_nxt = 8'(in_lat_r);
      end
   end

   // Interrupt grouping and routing.
   logic [NG-1:0] grp;
   logic [NL-1:0] line_nxt;
   logic [NL-1:0] line_r;
   logic [NG-1:0] grp_r;
   genvar s;
   generate
      for (s = 0; s < 2; s++) begin : g_ser
         assign grp[s] = ser_rx_rdy_in[s] || ser_sync_in[s] ||
                         (arm_tx_rdy_in[s] && ser_tx_rdy_in[s]) ||
                         (arm_tx_empty_in[s] && ser_tx_empty_in[s]);
      end
   endgenerate
   assign grp[2] = (arm_in_flag_in && in_rdy_r) ||
                   (arm_out_flag_in && out_rdy_r);
   assign grp[3] = tick_irq_route_in && arm_tick_in && tick_r;

   always_comb begin
      line_nxt = '0;
      for (int g = 0; g < NG; g++) begin
         for (int l = 0; l < NL; l++) begin
            if (grp[g] && irq_route_in[g*4 +: 4] == 4'(l)) begin
               line_nxt[l] = 1'b1;
            end
         end
      end
   end

   // Latch enable: strapped low keeps the byte on the pins from the first clock after reset,
   // otherwise it is driven only in the cycle after a data write, one cycle before that write's byte is loaded.
   logic oe_n_r, oe_n_nxt;
   assign oe_n_nxt = !(latch_oe_strap_in == 1'b0 || wr_data);

   // State registers; every output below is one of these flops.
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ack_d_r   <= 1'b0;
         stb_d_r   <= 1'b0;
         base_r    <= 32'h0;
         pre_r     <= 11'h0;
         out_rdy_r <= 1'b0;
         in_rdy_r  <= 1'b0;
         tick_r    <= 1'b0;
         in_lat_r  <= '0;
         dout_r    <= '0;
         aux_r     <= 1'b0;
         wr_ind_r  <= 1'b0;
         rdata_r   <= 8'h00;
         line_r    <= '0;
         grp_r     <= '0;
         oe_n_r    <= 1'b1;
      end else begin
         ack_d_r   <= ack_d_nxt;
         stb_d_r   <= stb_d_nxt;
         base_r    <= base_nxt;
         pre_r     <= pre_nxt;
         out_rdy_r <= out_rdy_nxt;
         in_rdy_r  <= in_rdy_nxt;
         tick_r    <= tick_nxt;
         in_lat_r  <= in_lat_nxt;
         dout_r    <= dout_nxt;
         aux_r     <= aux_nxt;
         wr_ind_r  <= wr_ind_nxt;
         rdata_r   <= rdata_nxt;
         line_r    <= line_nxt;
         grp_r     <= grp;
         oe_n_r    <= oe_n_nxt;
      end
   end

   assign pout_data_out      = dout_r;
   assign pout_data_oe_n_out = oe_n_r;
   assign pout_aux_out       = aux_r;
   assign pout_write_out     = wr_ind_r;
   assign io_rdata_out       = rdata_r;
   assign irq_line_out       = line_r;
   assign irq_group_out      = grp_r;
endmodule : ppf_board

// ==== src/ppf_fifo.sv ====
// Purpose: Small synchronous FIFO with valid/ready on both sides.
// Assumes: One clock, asynchronous active-low reset.
// Notes:   Depth must be a power of two.
`timescale 1ns/1ps
module ppf_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input  wire logic             clk_in,
   input  wire logic             rst_n_in,
   input  wire logic             wr_valid_in,
   output logic                  wr_ready_out,
   input  wire logic [WIDTH-1:0] wr_data_in,
   output logic                  rd_valid_out,
   input  wire logic             rd_ready_in,
   output logic      [WIDTH-1:0] rd_data_out
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW:0]      wp_r, wp_nxt, rp_r, rp_nxt;
   logic             push, pop;

   // Full and empty come straight from the pointers, so they never lie.
   assign wr_ready_out = (wp_r - rp_r) != (AW+1)'(DEPTH);
   assign rd_valid_out = wp_r != rp_r;
   assign rd_data_out  = mem_r[rp_r[AW-1:0]];
   assign push         = wr_valid_in && wr_ready_out;
   assign pop          = rd_valid_out && rd_ready_in;

   // Pointer advance.
   always_comb begin
      wp_nxt = push ? wp_r + 1'b1 : wp_r;
      rp_nxt = pop  ? rp_r + 1'b1 : rp_r;
   end

   // Pointer registers.
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wp_r <= '0;
         rp_r <= '0;
      end else begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
      end
   end

   // Storage has no reset; only written entries are ever read.
   always_ff @(posedge clk_in) begin
      if (push) begin
         mem_r[wp_r[AW-1:0]] <= wr_data_in;
      end
   end
endmodule : ppf_fifo

// ==== src/ppf_pkg.sv ====
// Purpose: Shared constants for the parallel port, flag and tick block.
// Assumes: Port addresses are 8-bit I/O port numbers.
// Notes:   All offsets, commands, bit positions and counts live here.
package ppf_pkg;
   localparam logic [7:0] PORT_DATA      = 8'h00;
   localparam logic [7:0] PORT_STATUS    = 8'h06;
   localparam logic [7:0] CMD_CLR_OUT    = 8'h20;
   localparam logic [7:0] CMD_CLR_IN     = 8'h30;
   localparam logic [7:0] CMD_CLR_TICK   = 8'h50;
   localparam int         BIT_OUT_RDY    = 0;
   localparam int         BIT_IN_RDY     = 1;
   localparam int         BIT_TICK       = 2;
   localparam logic [7:0] DATA_RESET     = 8'h00;
   // Base tick interval in nanoseconds, as printed (3.3280 ms).
   localparam longint     TICK_BASE_NS   = 64'd3328000;
   localparam longint     CLK_PERIOD_NS  = 64'd5;
   // Cycles per base interval, rounded down (never longer than printed).
   localparam int         TICK_BASE_CYC  = int'(TICK_BASE_NS / CLK_PERIOD_NS);
   localparam int         TICK_STEPS     = 12;
   localparam int         STROBE_CYC     = 1;
   localparam int         IRQ_GROUPS     = 4;
   localparam int         IRQ_LINES      = 10;
   localparam int         FIFO_DEPTH     = 4;
endpackage : ppf_pkg
